// ---- rfc_pkg.sv ----
// Package for the RTC flags and control block: bit positions, offsets,
// reset values and timing counts shared by the design.
// Assumes a single 25 MHz core clock.
`default_nettype none
package rfc_pkg;
	localparam int CLK_HZ = 25_000_000;
	// Oscillator start window at power-up, in ms
	localparam int OSC_START_MS = 5;
	localparam int OSC_START_CYC = (CLK_HZ / 1000) * OSC_START_MS;
	// Default update delay, in us
	localparam int UPD_DELAY_US = 350;
	localparam int UPD_DELAY_CYC = (CLK_HZ / 1_000_000) * UPD_DELAY_US;
	// Flags register byte offset within the RTC region
	localparam logic [3:0] FLAGS_OFS = 4'h0;
	localparam int BIT_READ_HOLD = 0;
	localparam int BIT_WRITE_FREEZE = 1;
	localparam int BIT_BACKUP_FAIL = 3;
	localparam int BIT_OSC_FAIL = 4;
	localparam int BIT_SUPPLY_FAIL = 5;
	localparam logic [7:0] FLAGS_RESET = 8'h00;
endpackage : rfc_pkg
`default_nettype wire

// ---- rfc_flags.sv ----
// RTC flags register with write-freeze and read-hold control.
// Assumes the host register port is synchronous to core_clk and that the
// analog supply and backup monitors arrive as synchronous levels.
`default_nettype none
module rfc_flags #(
	parameter int OSC_START_CYCLES = rfc_pkg::OSC_START_CYC,
	parameter int UPD_DELAY_CYCLES = rfc_pkg::UPD_DELAY_CYC
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic reg_sel,
	input wire logic reg_wr,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic supply_low,
	input wire logic backup_low,
	input wire logic osc_enable,
	input wire logic osc_running,
	input wire logic time_regs_written,
	input wire logic osc_fail_retained,
	output logic visible_update_en,
	output logic counter_load,
	output logic load_busy
);
	localparam int OW = $clog2(OSC_START_CYCLES + 1);
	localparam int UW = $clog2(UPD_DELAY_CYCLES + 1);

	logic flags_wr;
	logic [OW-1:0] osc_cnt_q;
	logic osc_chk_q;
	logic osc_fail_q;
	logic osc_timeout;
	logic osc_clr_pend_q;
	logic [UW-1:0] clr_cnt_q;
	logic backup_fail_q;
	logic bk_chk_q;
	logic write_freeze_q;
	logic read_hold_q;
	logic time_dirty_q;
	logic [UW-1:0] load_cnt_q;
	logic load_busy_q;
	logic counter_load_q;

	assign flags_wr = reg_sel & reg_wr & (reg_addr == rfc_pkg::FLAGS_OFS);
	// enabled oscillator still idle at the end of the window
	assign osc_timeout = osc_chk_q && !osc_running && osc_enable &&
		(osc_cnt_q == OW'(OSC_START_CYCLES - 1));

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			osc_cnt_q <= '0;
			osc_chk_q <= 1'b1;
		end
		else if (osc_chk_q)
		begin
			if (osc_running || !osc_enable)
				osc_chk_q <= 1'b0;
			else if (osc_cnt_q == OW'(OSC_START_CYCLES - 1))
				osc_chk_q <= 1'b0;
			else
				osc_cnt_q <= osc_cnt_q + 1'b1;
		end
	end

	// Retained value reloads one cycle after reset release, never under reset
	logic boot_q;
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			boot_q <= 1'b1;
		else
			boot_q <= 1'b0;
	end

	// osc flag only cleared by host
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			osc_fail_q <= 1'b0;
		else if (boot_q && osc_fail_retained)
			osc_fail_q <= 1'b1;
		// timeout sets flag; set wins over a pending clear
		else if (osc_timeout)
			osc_fail_q <= 1'b1;
		// clear lands after the update delay
		else if (osc_clr_pend_q && clr_cnt_q == UW'(UPD_DELAY_CYCLES - 1))
			osc_fail_q <= 1'b0;
	end

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			osc_clr_pend_q <= 1'b0;
			clr_cnt_q <= '0;
		end
		// A fresh timeout must not be wiped by an older pending clear
		else if (osc_timeout)
			osc_clr_pend_q <= 1'b0;
		else if (flags_wr && !reg_wdata[rfc_pkg::BIT_OSC_FAIL] && osc_fail_q)
		begin
			osc_clr_pend_q <= 1'b1;
			clr_cnt_q <= '0;
		end
		else if (osc_clr_pend_q)
		begin
			if (clr_cnt_q == UW'(UPD_DELAY_CYCLES - 1))
				osc_clr_pend_q <= 1'b0;
			else
				clr_cnt_q <= clr_cnt_q + 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			backup_fail_q <= 1'b0;
			bk_chk_q <= 1'b1;
		end
		else if (bk_chk_q)
		begin
			bk_chk_q <= 1'b0;
			backup_fail_q <= backup_low;
		end
		else if (flags_wr && !reg_wdata[rfc_pkg::BIT_BACKUP_FAIL])
			backup_fail_q <= 1'b0;
	end

	// freeze and hold reset to zero
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			write_freeze_q <= rfc_pkg::FLAGS_RESET[rfc_pkg::BIT_WRITE_FREEZE];
			read_hold_q <= rfc_pkg::FLAGS_RESET[rfc_pkg::BIT_READ_HOLD];
		end
		else if (flags_wr)
		begin
			write_freeze_q <= reg_wdata[rfc_pkg::BIT_WRITE_FREEZE];
			read_hold_q <= reg_wdata[rfc_pkg::BIT_READ_HOLD];
		end
	end

	// remember whether time changed while frozen
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			time_dirty_q <= 1'b0;
		// writes outside freeze are not tracked
		else if (write_freeze_q && time_regs_written)
			time_dirty_q <= 1'b1;
		else if (counter_load_q)
			time_dirty_q <= 1'b0;
	end

	// load completes within the update delay
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			counter_load_q <= 1'b0;
			load_busy_q <= 1'b0;
			load_cnt_q <= '0;
		end
		// freeze falling edge with a changed time starts the load
		else if (flags_wr && write_freeze_q &&
			!reg_wdata[rfc_pkg::BIT_WRITE_FREEZE] &&
			(time_dirty_q || time_regs_written))
		begin
			counter_load_q <= 1'b1;
			load_busy_q <= 1'b1;
			load_cnt_q <= '0;
		end
		else
		begin
			counter_load_q <= 1'b0;
			if (load_busy_q)
			begin
				if (load_cnt_q == UW'(UPD_DELAY_CYCLES - 1))
					load_busy_q <= 1'b0;
				else
					load_cnt_q <= load_cnt_q + 1'b1;
			end
		end
	end

	assign counter_load = counter_load_q;
	assign load_busy = load_busy_q;
	// visible time frozen by either bit or pending load
	assign visible_update_en = !write_freeze_q && !read_hold_q && !load_busy_q;

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			reg_rdata <= 8'h00;
		else if (reg_sel && (reg_addr == rfc_pkg::FLAGS_OFS))
		begin
			reg_rdata <= 8'h00;
			reg_rdata[rfc_pkg::BIT_SUPPLY_FAIL] <= supply_low;
			reg_rdata[rfc_pkg::BIT_OSC_FAIL] <= osc_fail_q;
			reg_rdata[rfc_pkg::BIT_BACKUP_FAIL] <= backup_fail_q;
			reg_rdata[rfc_pkg::BIT_WRITE_FREEZE] <= write_freeze_q;
			reg_rdata[rfc_pkg::BIT_READ_HOLD] <= read_hold_q;
		end
		else
			reg_rdata <= 8'h00;
	end
endmodule : rfc_flags
`default_nettype wire

// ---- rfc_chk_properties.sv ----
// Port checker for rfc_flags.
// Assumes an update delay of 8 cycles.
`default_nettype none
module rfc_chk (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic reg_sel,
	input wire logic reg_wr,
	input wire logic [3:0] reg_addr,
	input wire logic supply_low,
	input wire logic [7:0] reg_rdata,
	input wire logic visible_update_en,
	input wire logic counter_load,
	input wire logic load_busy
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (!rst_b);
	sequence s_rd;
		reg_sel && !reg_wr && reg_addr == 4'h0;
	endsequence
	sequence s_busy;
		load_busy[*8] ##1 !load_busy;
	endsequence
	property p_ld; counter_load |-> $rose(load_busy); endproperty
	property p_busy; $rose(load_busy) |-> s_busy; endproperty
	property p_vis; load_busy |-> !visible_update_en; endproperty
	property p_sup; s_rd |=> reg_rdata[5] == $past(supply_low); endproperty
	property p_idle; !reg_sel |=> reg_rdata == 8'h00; endproperty
	// Read data shows the state before its access edge, so compare with then
	property p_frz; reg_rdata[1] |-> !$past(visible_update_en); endproperty
	property p_hold; reg_rdata[0] |-> !$past(visible_update_en); endproperty
	property p_run;
		s_rd ##1 reg_rdata[1:0] == 2'b00 |-> visible_update_en || load_busy;
	endproperty
	a_ld: assert property (p_ld) else $error("load");
	a_busy: assert property (p_busy) else $error("busy");
	a_vis: assert property (p_vis) else $error("vis");
	a_sup: assert property (p_sup) else $error("supply");
	a_idle: assert property (p_idle) else $error("idle");
	a_frz: assert property (p_frz) else $error("freeze");
	a_hold: assert property (p_hold) else $error("hold");
	a_run: assert property (p_run) else $error("run");
endmodule : rfc_chk
bind rfc_flags rfc_chk chk_u (.*);
`default_nettype wire

// ---- rfc_host.sv ----
// Host model: one byte access at a time.
// Assumes sampling on rising core_clk.
`default_nettype none
module rfc_host (
	input wire logic core_clk,
	input wire logic [7:0] reg_rdata,
	output logic reg_sel = 1'b0,
	output logic reg_wr = 1'b0,
	output logic [3:0] reg_addr = 4'h0,
	output logic [7:0] reg_wdata = 8'h00,
	output logic [7:0] rd_seen
);
	timeunit 1ns;
	timeprecision 1ns;
	// freeze before edits; the bench orders the writes
	task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d);
		reg_sel <= 1'b1;
		reg_wr <= w;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_sel <= 1'b0;
		reg_wr <= 1'b0;
		// Released data scrambled, never left at its last value
		reg_wdata <= ~d;
		#1 rd_seen = reg_rdata;
		@(posedge core_clk);
	endtask : acc
endmodule : rfc_host
`default_nettype wire

// ---- tb.sv ----
// Bench for rfc_flags with host model and flags model.
// Assumes short counts: oscillator window 20, update delay 8.
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk = 1'b0, rst_b = 1'b0, sup = 1'b0, bl = 1'b0, orun = 1'b1;
	logic oret = 1'b0, trw = 1'b0, sel, wr, upd, ld, bsy;
	logic oen = 1'b1;
	logic [3:0] adr;
	logic [7:0] wd, rd, q;
	logic [15:0] lf = 16'hd660;
	int fail_count = 0, samples_checked = 0, loads = 0, m = 0;
	always #20 core_clk = ~core_clk;
	always @(posedge core_clk) if (ld === 1'b1) loads++;
	rfc_host host_u (.core_clk(core_clk), .reg_rdata(rd), .reg_sel(sel),
		.reg_wr(wr), .reg_addr(adr), .reg_wdata(wd), .rd_seen(q));
	rfc_flags #(.OSC_START_CYCLES(20), .UPD_DELAY_CYCLES(8)) dut_u (
		.core_clk(core_clk), .rst_b(rst_b), .reg_sel(sel), .reg_wr(wr),
		.reg_addr(adr), .reg_wdata(wd), .reg_rdata(rd), .supply_low(sup),
		.backup_low(bl), .osc_enable(oen), .osc_running(orun),
		.time_regs_written(trw), .osc_fail_retained(oret),
		.visible_update_en(upd), .counter_load(ld), .load_busy(bsy));
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr
	task automatic give_verdict(input int extra);
		fail_count += extra;
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : give_verdict
	task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
		samples_checked++;
		if (s !== e)
		begin
			fail_count++;
			$display("MISMATCH %s exp %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic rdchk();
		lf = lfsr(lf);
		sup <= lf[0];
		@(posedge core_clk);
		host_u.acc(1'b0, 4'h0, 8'h00);
		chk("flags", q, 8'(m) | {2'b00, sup, 5'h00});
	endtask : rdchk
	task automatic wrf(input logic [3:0] a, input logic [7:0] d);
		host_u.acc(1'b1, a, d);
		// Osc clear is lagged, so the model drops it by hand
		if (a == 4'h0)
			m = (m & (d | 8'h10) & 8'h18) | (d & 8'h03);
	endtask : wrf
	task automatic rst(input logic b, input logic o, input logic r);
		rst_b <= 1'b0;
		bl <= b;
		oret <= o;
		orun <= r;
		repeat (3) @(posedge core_clk);
		rst_b <= 1'b1;
		repeat (2) @(posedge core_clk);
		m = {o, b, 3'b000};
	endtask : rst
	initial
	begin
		rst(1'b1, 1'b1, 1'b1);
		rdchk();
		wrf(4'h0, 8'h02);
		rdchk();
		chk("upd", {7'h00, upd}, 8'h00);
		repeat (9) @(posedge core_clk);
		m = m & 8'h0f;
		rdchk();
		wrf(4'h0, 8'h1a);
		wrf(4'h5, 8'h03);
		rdchk();
		trw <= 1'b1;
		@(posedge core_clk);
		trw <= 1'b0;
		wrf(4'h0, 8'h01);
		repeat (20) if (bsy !== 1'b0) @(posedge core_clk);
		if (bsy !== 1'b0)
			give_verdict(1);
		chk("loads", 8'(loads), 8'h01);
		rdchk();
		chk("upd", {7'h00, upd}, 8'h00);
		wrf(4'h0, 8'h02);
		wrf(4'h0, 8'h00);
		chk("upd", {7'h00, upd}, 8'h01);
		chk("loads", 8'(loads), 8'h01);
		rst(1'b0, 1'b0, 1'b0);
		repeat (25) @(posedge core_clk);
		m = 8'h10;
		rdchk();
		oen <= 1'b0;
		rst(1'b0, 1'b0, 1'b0);
		repeat (25) @(posedge core_clk);
		rdchk();
		give_verdict(0);
	end
endmodule : tb
`default_nettype wire
